// *** rtl/abu_top.v ***
// address breakpoint unit: compares the cpu address bus against a programmed
// address and drives breakpoint_out, pulsed or latched, with an apb register port
// assumes cpu_addr and cpu_clk_tick are synchronous to pclk; one tick per cpu clock
//
// Contract
// - output high on enabled address match
// - pulse mode gives eight cpu clock pulse
// - latched mode holds until hit cleared by one
// - output low by default and during reset
// - reset clears enable, mode, address, hit flag
// - cpu clock starts at 12 MHz, selectable
//
// Design decisions made here: the address map and register access over APB.
`include "abu_defs.vh"

module abu_top
(
  input  wire                      pclk,
  input  wire                      presetn,
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [`ABU_AW-1:0]        paddr,
  input  wire [`ABU_DW-1:0]        pwdata,
  output wire                      pready,
  output reg  [`ABU_DW-1:0]        prdata,
  output wire                      pslverr,
  input  wire                      power_on_reset,
  input  wire [`ABU_CPU_AW-1:0]    cpu_addr,
  input  wire                      cpu_clk_tick,
  output wire [`ABU_SPEED_W-1:0]   cpu_speed_sel,
  output wire                      breakpoint_out,
  output wire                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg                              match_enable_q;
  reg                              pulse_mode_select_q;
  reg                              hit_q;
  reg                              hit_d;
  reg  [`ABU_CPU_AW-1:0]           match_address_pair_q;
  reg  [`ABU_SPEED_W-1:0]          speed_q;
  reg  [`ABU_IRQ_W-1:0]            sts_q;
  reg  [`ABU_IRQ_W-1:0]            sts_d;
  reg  [`ABU_IRQ_W-1:0]            mask_q;
  reg  [`ABU_IRQ_W-1:0]            mask_d;
  reg  [`ABU_PULSE_W-1:0]          cnt_q;
  reg  [`ABU_PULSE_W-1:0]          cnt_d;
  reg                              match_q;
  reg                              pin_q;
  reg                              pin_d;
  reg                              irq_q;
  reg  [`ABU_DW-1:0]               rdata_d;
  reg                              mapped;

  wire                             setup_ph;
  wire                             wr_acc;
  wire                             match_now;
  wire                             match_evt;
  wire                             pulse_start;
  wire                             pulse_end;
  wire                             wr_ctrl;
  wire                             wr_addr;
  wire                             wr_sts;
  wire                             wr_mask;
  wire                             wr_speed;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; zero wait states, so pready is tied high by design
  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  assign wr_ctrl  = wr_acc & (paddr == `ABU_OFF_CTRL);
  assign wr_addr  = wr_acc & (paddr == `ABU_OFF_ADDR);
  assign wr_sts   = wr_acc & (paddr == `ABU_OFF_STS);
  assign wr_mask  = wr_acc & (paddr == `ABU_OFF_MASK);
  assign wr_speed = wr_acc & (paddr == `ABU_OFF_SPEED);

  always @*
  begin
    mapped  = 1'b1;
    rdata_d = `ABU_RST_WORD;
    case (paddr)
      `ABU_OFF_CTRL:
      begin
        rdata_d[`ABU_CTRL_EN]    = match_enable_q;
        rdata_d[`ABU_CTRL_PULSE] = pulse_mode_select_q;
        rdata_d[`ABU_CTRL_HIT]   = hit_q;
      end
      `ABU_OFF_ADDR:
        rdata_d[`ABU_CPU_AW-1:0] = match_address_pair_q;
      `ABU_OFF_STS:
        rdata_d[`ABU_IRQ_W-1:0] = sts_q;
      `ABU_OFF_MASK:
        rdata_d[`ABU_IRQ_W-1:0] = mask_q;
      `ABU_OFF_SPEED:
        rdata_d[`ABU_SPEED_W-1:0] = speed_q;
      default:
        mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // match detection; an address that dwells on the target counts as one event
  assign match_now   = match_enable_q & (cpu_addr == match_address_pair_q);
  assign match_evt   = match_now & ~match_q;
  assign pulse_start = match_evt & (cnt_q == `ABU_PULSE_ZERO);
  assign pulse_end   = cpu_clk_tick & (cnt_q == `ABU_PULSE_ONE);

  always @*
  begin
    // set wins over a software clear in the same cycle
    hit_d = hit_q;
    if (wr_ctrl & pwdata[`ABU_CTRL_HIT])
      hit_d = 1'b0;
    if (match_evt)
      hit_d = 1'b1;
  end

  always @*
  begin
    // a new match while busy is ignored, so the pulse keeps its eight clocks
    cnt_d = cnt_q;
    if (pulse_start & pulse_mode_select_q)
      cnt_d = `ABU_PULSE_LEN;
    else if (cpu_clk_tick & (cnt_q != `ABU_PULSE_ZERO))
      cnt_d = cnt_q - `ABU_PULSE_ONE;
  end

  always @*
  begin
    if (pulse_mode_select_q)
      pin_d = (cnt_d != `ABU_PULSE_ZERO);
    else
      pin_d = hit_d;
  end

  always @*
  begin
    mask_d = mask_q;
    if (wr_mask)
      mask_d = pwdata[`ABU_IRQ_W-1:0];
  end

  always @*
  begin
    sts_d = sts_q;
    if (wr_sts)
      sts_d = sts_q & ~pwdata[`ABU_IRQ_W-1:0];
    if (match_evt)
      sts_d[`ABU_IRQ_MATCH] = 1'b1;
    if (pulse_end)
      sts_d[`ABU_IRQ_PEND] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; power_on_reset acts as a synchronous clear of the whole unit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_enable_q       <= 1'b0;
      pulse_mode_select_q  <= 1'b0;
      match_address_pair_q <= `ABU_RST_ADDR;
      hit_q                <= 1'b0;
      speed_q              <= `ABU_SPEED_12;
      sts_q                <= `ABU_RST_IRQ;
      mask_q               <= `ABU_RST_IRQ;
      cnt_q                <= `ABU_PULSE_ZERO;
      match_q              <= 1'b0;
      pin_q                <= 1'b0;
      irq_q                <= 1'b0;
      prdata               <= `ABU_RST_WORD;
    end
    else if (power_on_reset)
    begin
      match_enable_q       <= 1'b0;
      pulse_mode_select_q  <= 1'b0;
      match_address_pair_q <= `ABU_RST_ADDR;
      hit_q                <= 1'b0;
      speed_q              <= `ABU_SPEED_12;
      sts_q                <= `ABU_RST_IRQ;
      mask_q               <= `ABU_RST_IRQ;
      cnt_q                <= `ABU_PULSE_ZERO;
      match_q              <= 1'b0;
      pin_q                <= 1'b0;
      irq_q                <= 1'b0;
      prdata               <= `ABU_RST_WORD;
    end
    else
    begin
      if (wr_ctrl)
      begin
        match_enable_q      <= pwdata[`ABU_CTRL_EN];
        pulse_mode_select_q <= pwdata[`ABU_CTRL_PULSE];
      end
      if (wr_addr)
        match_address_pair_q <= pwdata[`ABU_CPU_AW-1:0];
      // the unused code reads back but the clock source treats it as 48 MHz
      if (wr_speed)
        speed_q <= pwdata[`ABU_SPEED_W-1:0];
      mask_q <= mask_d;
      // read data is taken in setup so it stands through the whole access phase
      if (setup_ph)
        prdata <= rdata_d;
      hit_q   <= hit_d;
      sts_q   <= sts_d;
      cnt_q   <= cnt_d;
      match_q <= match_now;
      pin_q   <= pin_d;
      // next-state status and mask, so irq has no lag behind a mask write
      irq_q   <= |(sts_d & mask_d);
    end
  end

  assign breakpoint_out = pin_q;
  assign cpu_speed_sel  = speed_q;
  assign irq            = irq_q;

endmodule // abu_top

// *** common/abu_defs.vh ***
// constants for the address breakpoint unit: register map, field positions, reset values
// assumes a 32-bit apb slave port with word-aligned registers
`ifndef ABU_DEFS_VH
`define ABU_DEFS_VH

`define ABU_AW            12
`define ABU_CPU_AW        16
`define ABU_DW            32

// register byte offsets
`define ABU_OFF_CTRL      12'h000
`define ABU_OFF_ADDR      12'h004
`define ABU_OFF_STS       12'h008
`define ABU_OFF_MASK      12'h00C
`define ABU_OFF_SPEED     12'h010

// debug_match_control fields
`define ABU_CTRL_EN       0
`define ABU_CTRL_PULSE    1
`define ABU_CTRL_HIT      2

// interrupt status / mask fields
`define ABU_IRQ_MATCH     0
`define ABU_IRQ_PEND      1
`define ABU_IRQ_W         2

// cpu clock speed select codes
`define ABU_SPEED_W       2
`define ABU_SPEED_12      2'h0
`define ABU_SPEED_24      2'h1
`define ABU_SPEED_48      2'h2

// reset values
`define ABU_RST_ADDR      16'h0000
`define ABU_RST_IRQ       2'h0
`define ABU_RST_WORD      32'h0000_0000

// pulse length in cpu clocks
`define ABU_PULSE_W       4
`define ABU_PULSE_LEN     4'h8
`define ABU_PULSE_ONE     4'h1
`define ABU_PULSE_ZERO    4'h0

`endif

// *** bench/abu_top_sva.sv ***
// port checker for the breakpoint unit
// assumes one pclk domain; shadows control and address writes
`include "abu_defs.vh"
module abu_top_sva
(
  input logic                    pclk, presetn, psel, penable, pwrite, power_on_reset,
  input logic [`ABU_AW-1:0]      paddr,
  input logic [`ABU_DW-1:0]      pwdata,
  input logic [`ABU_CPU_AW-1:0]  cpu_addr,
  input logic [`ABU_SPEED_W-1:0] cpu_speed_sel,
  input logic                    cpu_clk_tick, breakpoint_out, irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  ctl_q;
  logic [15:0] adr_q;
  logic [3:0]  tk_q;
  wire         wr  = psel && penable && pwrite;
  wire         clr = wr && paddr == `ABU_OFF_CTRL && pwdata[`ABU_CTRL_HIT];
  wire         m   = ctl_q[0] && cpu_addr == adr_q;
  wire [1:0]   spd = pwdata[1:0];
  // shadow copy, so a due match is known without the design's internals
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn || power_on_reset)
    begin
      ctl_q <= 2'h0;
      adr_q <= 16'h0000;
      tk_q  <= 4'h0;
    end
    else
    begin
      if (wr && paddr == `ABU_OFF_CTRL) ctl_q <= pwdata[1:0];
      if (wr && paddr == `ABU_OFF_ADDR) adr_q <= pwdata[15:0];
      tk_q <= breakpoint_out ? tk_q + {3'h0, cpu_clk_tick} : 4'h0;
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || power_on_reset);
  sequence s_ev; $rose(m) && !breakpoint_out; endsequence
  property p_on; s_ev |=> breakpoint_out; endproperty
  a_on: assert property (p_on) else $error("no output on match");
  property p_len; ctl_q[1] && breakpoint_out |=>
    breakpoint_out != ($past(cpu_clk_tick) && $past(tk_q) == 4'h7); endproperty
  a_len: assert property (p_len) else $error("pulse length wrong");
  property p_latch; !ctl_q[1] && breakpoint_out && !clr |=> breakpoint_out; endproperty
  a_latch: assert property (p_latch) else $error("latched output fell");
  property p_clear; !ctl_q[1] && clr && !$rose(m) |=> !breakpoint_out; endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");
  property p_rst; disable iff (1'b0) !presetn |-> !breakpoint_out && !irq; endproperty
  a_rst: assert property (p_rst) else $error("output high in reset");
  property p_por; disable iff (!presetn)
    power_on_reset |=> !breakpoint_out && !irq && cpu_speed_sel == 2'h0; endproperty
  a_por: assert property (p_por) else $error("state kept over reset");
  property p_spd; wr && paddr == `ABU_OFF_SPEED |=> cpu_speed_sel == $past(spd); endproperty
  a_spd: assert property (p_spd) else $error("speed not applied");
endmodule // abu_top_sva

// *** bench/abu_cpu_model.sv ***
// cpu side: address bus and one tick per cpu clock
// assumes pclk stands for the fastest cpu clock
module abu_cpu_model
(
  input  logic        pclk,
  input  logic [1:0]  speed,
  input  logic [15:0] goal,
  output logic [15:0] cpu_addr,
  output logic        cpu_clk_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q = 2'h0;
  initial cpu_clk_tick = 1'b0;
  initial cpu_addr = 16'h0000;
  // slower codes tick every second or fourth cycle
  always @(posedge pclk)
  begin
    div_q        <= div_q + 2'h1;
    cpu_clk_tick <= (div_q & (2'h3 >> speed)) == 2'h0;
    cpu_addr     <= goal;
  end
endmodule // abu_cpu_model

// *** bench/address_breakpoint_unit_tb.sv ***
// top bench: apb master, cpu model, bound checker
// assumes abu_defs.vh on the include path
`include "abu_defs.vh"
module address_breakpoint_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, power_on_reset = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, n;
  logic [15:0] goal = 16'h0000, a, cpu_addr;
  logic [1:0]  cpu_speed_sel;
  logic        pready, pslverr, cpu_clk_tick, breakpoint_out, irq, er;
  int          n_mismatch = 0, tests_run = 0, cyc = 0, k;
  abu_top abu_top_inst (.*);
  abu_cpu_model abu_cpu_model_inst (.pclk, .speed(cpu_speed_sel), .goal, .cpu_addr, .cpu_clk_tick);
  initial forever #25 pclk = ~pclk;
  always @(posedge pclk)
    if (++cyc == 20000)
    begin
      n_mismatch++;
      end_of_test;
    end
  function automatic logic [31:0] cw(input logic hit, pm, en);
    return {29'h0, hit, pm, en};
  endfunction
  task automatic chk(input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    presetn <= 1'b0; // a real falling edge, so the async reset acts at time zero
    k = $urandom(32'h30e1);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (k = 0; k < 6; k++)
    begin
      apb(0, 12'(k * 4), 0);
      chk(r, 0);
      chk(er, k == 5);
    end
    for (int s = 0; s < 3; s++)
    begin
      a = 16'($urandom);
      apb(1, `ABU_OFF_SPEED, s);
      apb(1, `ABU_OFF_ADDR, a);
      chk(cpu_speed_sel, s);
      apb(1, `ABU_OFF_CTRL, cw(1, 1, 1));
      n = 0;
      // a second match a few cycles in must not stretch the pulse
      for (int i = 0; i < 90; i++)
      begin
        @(posedge pclk);
        goal <= (i == 2) ? ~a : a;
        @(negedge pclk) n += 32'(breakpoint_out && cpu_clk_tick);
      end
      chk(n, 8);
      apb(0, `ABU_OFF_CTRL, 0);
      chk(r, cw(1, 1, 1));
      goal <= ~a;
    end
    apb(0, `ABU_OFF_STS, 0);
    chk(r, 3);
    apb(1, `ABU_OFF_CTRL, cw(1, 1, 0));
    goal <= a;
    repeat (5) @(negedge pclk);
    chk(breakpoint_out, 0);
    apb(1, `ABU_OFF_MASK, 3);
    apb(1, `ABU_OFF_CTRL, cw(0, 0, 1));
    repeat (20) @(negedge pclk);
    chk(breakpoint_out, 1);
    chk(irq, 1);
    apb(1, `ABU_OFF_CTRL, cw(0, 0, 1));
    @(negedge pclk) chk(breakpoint_out, 1);
    apb(1, `ABU_OFF_CTRL, cw(1, 0, 1));
    @(negedge pclk) chk(breakpoint_out, 0);
    apb(1, `ABU_OFF_STS, 3);
    repeat (2) @(negedge pclk) chk(irq, 0);
    goal <= ~a;
    repeat (2) @(posedge pclk);
    goal <= a;
    repeat (4) @(posedge pclk);
    power_on_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    power_on_reset <= 1'b0;
    chk(breakpoint_out, 0);
    apb(0, `ABU_OFF_ADDR, 0);
    chk(r, 0);
    apb(0, `ABU_OFF_CTRL, 0);
    chk(r, 0);
    end_of_test;
  end
endmodule // address_breakpoint_unit_tb
bind abu_top abu_top_sva abu_top_sva_inst (.*);
